//--- cdp_map.svh
// Register map, field positions and reset values for the channel dividers.
// Assumes byte-wide registers, each in its own 32-bit word at four times its index.
`ifndef CDP_MAP_SVH
`define CDP_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------------------------------
`define CDP_IDX_BASE        9'h190
`define CDP_IDX_LAST        9'h1a7
`define CDP_REG_DEPTH       24
`define CDP_IDX_CH0_COUNT   9'h190
`define CDP_IDX_CH0_OFFSET  9'h191
`define CDP_IDX_CH0_CORR    9'h192
`define CDP_IDX_CH1_COUNT   9'h196
`define CDP_IDX_CH1_OFFSET  9'h197
`define CDP_IDX_CH1_CORR    9'h198
`define CDP_IDX_CH2_S1      9'h199
`define CDP_IDX_CH2_S2      9'h19b
`define CDP_IDX_CH2_BYP     9'h19c
`define CDP_IDX_CH2_CORR    9'h19d
`define CDP_IDX_CH3_S1      9'h19e
`define CDP_IDX_CH3_S2      9'h1a0
`define CDP_IDX_CH3_BYP     9'h1a1
`define CDP_IDX_CH3_CORR    9'h1a2
`define CDP_IDX_SYNC        9'h1a3
`define CDP_IDX_B_ENABLE    9'h1a4
`define CDP_IDX_STATUS      9'h1a5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDP_LOW_MSB         7
`define CDP_LOW_LSB         4
`define CDP_HIGH_MSB        3
`define CDP_HIGH_LSB        0
`define CDP_BEGIN_HIGH_BIT  4
`define CDP_OFFSET_MSB      3
`define CDP_ONE_BYP_BIT     7
`define CDP_STAGE1_BYP_BIT  4
`define CDP_STAGE2_BYP_BIT  5
`define CDP_CORR_DIS_BIT    0
`define CDP_DIRECT_BIT      1
`define CDP_SYNC_BIT        0

// ----------------------------------------------------------------
// Write masks, reset values and delay-code constants
// ----------------------------------------------------------------
`define CDP_MASK_COUNT      8'hff
`define CDP_MASK_OFFSET     8'h9f
`define CDP_MASK_CORR_ONE   8'h03
`define CDP_MASK_CORR_TWO   8'h01
`define CDP_MASK_BYP        8'h30
`define CDP_MASK_B_ENABLE   8'h03
`define CDP_MASK_NONE       8'h00
`define CDP_REG_RESET       8'h00
`define CDP_CODE_SHORT_MAX  5'h0f
`define CDP_CODE_LONG_BASE  5'h10

`endif

//--- cdp_pkg.sv
// Types shared by the channel divider block.
// Assumes cdp_map.svh is on the include path.
`include "cdp_map.svh"

package cdp_pkg;

    typedef logic [`CDP_REG_DEPTH-1:0][7:0] cdp_regs_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [10:0] address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } cdp_av_req_t;

    typedef struct packed {
        logic [3:0] high_cnt;
        logic [3:0] low_cnt;
        logic       bypass;
        logic       corr_dis;
        logic       direct;
        logic [4:0] code;
    } cdp_stage_cfg_t;

    typedef struct packed {
        logic [6:0] halves;
        logic [6:0] wait_cnt;
        logic       prev_in;
        logic       out;
    } cdp_stage_t;

    typedef struct packed {
        cdp_regs_t            regs;
        logic                 wreq;
        logic [31:0]          rdata;
        logic                 sync;
        logic                 in_clk;
        cdp_stage_t [5:0]     stage;
        logic [1:0]           out_b;
    } cdp_state_t;

endpackage : cdp_pkg

//--- cdp_channel_divider.sv
// Four clock channel dividers (two single-stage, two cascaded) with duty correction,
// coarse start delay on channels 0 and 1 and an Avalon-MM register slave.
// Assumes ref_clk runs at twice the divider input rate: one input cycle is two ref_clk
// cycles, giving the half-cycle resolution that odd-ratio correction needs.
//
// How it works
// - Correction is on after reset; only a set disable bit turns it off.
// - Uncorrected active divider is high (high+1) of (high+low+2) input cycles.
// - Bypassed divider passes its input unchanged; correction does not act on it.
// - Corrected divider gives 50 percent for odd and even ratios alike.
// - Direct route passes the input clock untouched, keeping its duty.
// - Rising edge is delayed a whole number of input cycles from a zero offset.
// - Delay code is 16 x begin-high plus offset; codes up to 15 delay directly.
// - Codes of 16 or more delay by code minus 16 plus low count plus one.
// - Offsets act only at a sync, which software must trigger after writing.
// - Channels 2 and 3 cascade two stages; ratio is the product, bypass is one.
// - Channel 2 stage one counts and both bypass bits sit at fixed places.
// - Channel 1 begin-high, offset and counts sit at fixed places.
// - Channels 2 and 3 have a single-ended B output, off until enabled.
// - One disable bit per cascaded channel turns correction off for both stages.
// - Uncorrected active stage is high high+1 and low low+1 input cycles, ratios 2 to 32.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps

module cdp_channel_divider (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire cdp_pkg::cdp_av_req_t av_req,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    output logic [3:0]               clk_out,
    output logic [1:0]               clk_out_b
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] reg_at(input cdp_pkg::cdp_regs_t r, input logic [8:0] idx);
        logic [8:0] off;
        off = idx - `CDP_IDX_BASE;
        return r[off[4:0]];
    endfunction : reg_at

    function automatic logic idx_mapped(input logic [8:0] idx);
        return (idx >= `CDP_IDX_BASE) && (idx <= `CDP_IDX_LAST);
    endfunction : idx_mapped

    function automatic logic [7:0] write_mask(input logic [8:0] idx);
        logic [7:0] m;
        m = `CDP_MASK_NONE;
        unique case (idx)
            `CDP_IDX_CH0_COUNT, `CDP_IDX_CH1_COUNT, `CDP_IDX_CH2_S1, `CDP_IDX_CH2_S2,
            `CDP_IDX_CH3_S1, `CDP_IDX_CH3_S2:     m = `CDP_MASK_COUNT;
            `CDP_IDX_CH0_OFFSET, `CDP_IDX_CH1_OFFSET: m = `CDP_MASK_OFFSET;
            `CDP_IDX_CH0_CORR, `CDP_IDX_CH1_CORR:     m = `CDP_MASK_CORR_ONE;
            `CDP_IDX_CH2_CORR, `CDP_IDX_CH3_CORR:     m = `CDP_MASK_CORR_TWO;
            `CDP_IDX_CH2_BYP, `CDP_IDX_CH3_BYP:       m = `CDP_MASK_BYP;
            `CDP_IDX_B_ENABLE:                        m = `CDP_MASK_B_ENABLE;
            default:                                  m = `CDP_MASK_NONE;
        endcase
        return m;
    endfunction : write_mask

    // Stages: 0 ch0, 1 ch1, 2 ch2 first, 3 ch2 second, 4 ch3 first, 5 ch3 second
    function automatic cdp_pkg::cdp_stage_cfg_t stage_cfg(input cdp_pkg::cdp_regs_t r,
                                                          input int s);
        cdp_pkg::cdp_stage_cfg_t c;
        logic [7:0]              cnt;
        logic [7:0]              aux;
        logic [7:0]              corr;
        c   = '0;
        cnt = '0;
        aux = '0;
        corr = '0;
        unique case (s)
            0: begin
                cnt  = reg_at(r, `CDP_IDX_CH0_COUNT);
                aux  = reg_at(r, `CDP_IDX_CH0_OFFSET);
                corr = reg_at(r, `CDP_IDX_CH0_CORR);
            end
            1: begin
                cnt  = reg_at(r, `CDP_IDX_CH1_COUNT);
                aux  = reg_at(r, `CDP_IDX_CH1_OFFSET);
                corr = reg_at(r, `CDP_IDX_CH1_CORR);
            end
            2, 3: begin
                cnt  = reg_at(r, (s == 2) ? `CDP_IDX_CH2_S1 : `CDP_IDX_CH2_S2);
                aux  = reg_at(r, `CDP_IDX_CH2_BYP);
                corr = reg_at(r, `CDP_IDX_CH2_CORR);
            end
            default: begin
                cnt  = reg_at(r, (s == 4) ? `CDP_IDX_CH3_S1 : `CDP_IDX_CH3_S2);
                aux  = reg_at(r, `CDP_IDX_CH3_BYP);
                corr = reg_at(r, `CDP_IDX_CH3_CORR);
            end
        endcase
        c.low_cnt  = cnt[`CDP_LOW_MSB:`CDP_LOW_LSB];
        c.high_cnt = cnt[`CDP_HIGH_MSB:`CDP_HIGH_LSB];
        c.corr_dis = corr[`CDP_CORR_DIS_BIT];
        if (s < 2) begin
            c.bypass = aux[`CDP_ONE_BYP_BIT];
            c.direct = corr[`CDP_DIRECT_BIT];
            c.code   = aux[`CDP_BEGIN_HIGH_BIT:0];
        end else begin
            c.bypass = (s == 2 || s == 4) ? aux[`CDP_STAGE1_BYP_BIT] : aux[`CDP_STAGE2_BYP_BIT];
        end
        return c;
    endfunction : stage_cfg

    function automatic logic [5:0] ratio(input cdp_pkg::cdp_stage_cfg_t c);
        return 6'({2'b00, c.high_cnt} + {2'b00, c.low_cnt} + 6'h02);
    endfunction : ratio

    // Start delay in half input cycles
    function automatic logic [6:0] delay_halves(input cdp_pkg::cdp_stage_cfg_t c);
        logic [5:0] cyc;
        if (c.code <= `CDP_CODE_SHORT_MAX)
            cyc = {1'b0, c.code};
        else
            cyc = 6'({1'b0, c.code} - {1'b0, `CDP_CODE_LONG_BASE} + {2'b00, c.low_cnt} + 6'h01);
        return {cyc, 1'b0};
    endfunction : delay_halves

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cdp_pkg::cdp_state_t q;
    cdp_pkg::cdp_state_t d;

    logic [8:0] bus_idx;
    assign bus_idx = av_req.address[10:2];

    logic [7:0] b_en;
    assign b_en = reg_at(q.regs, `CDP_IDX_B_ENABLE);

    always_comb begin
        cdp_pkg::cdp_stage_cfg_t c;
        logic                    src;
        logic                    edge_seen;
        logic [6:0]              hi_halves;
        logic [6:0]              per_halves;
        logic [8:0]              off;
        c          = '0;
        off        = '0;
        src        = 1'b0;
        edge_seen  = 1'b0;
        hi_halves  = '0;
        per_halves = '0;
        d          = q;
        d.sync     = 1'b0;
        d.wreq     = 1'b1;

        // Bus: one wait cycle, then the access completes
        if ((av_req.read || av_req.write) && q.wreq) begin
            d.wreq  = 1'b0;
            d.rdata = '0;
            if (bus_idx == `CDP_IDX_STATUS)
                d.rdata[5:0] = {q.stage[5].out, q.stage[4].out, q.stage[3].out,
                                q.stage[2].out, q.stage[1].out, q.stage[0].out};
            else if (idx_mapped(bus_idx))
                d.rdata[7:0] = reg_at(q.regs, bus_idx) & write_mask(bus_idx);
        end
        if (av_req.write && !q.wreq && av_req.byteenable[0] && idx_mapped(bus_idx)) begin
            off = bus_idx - `CDP_IDX_BASE;
            d.regs[off[4:0]] = av_req.writedata[7:0] & write_mask(bus_idx);
            // Offsets only land at this pulse, not at the register write
            if (bus_idx == `CDP_IDX_SYNC)
                d.sync = av_req.writedata[`CDP_SYNC_BIT];
        end

        // Divider input: forced low at sync, then toggles every cycle
        d.in_clk = q.sync ? 1'b0 : ~q.in_clk;

        for (int s = 0; s < 6; s++) begin
            c          = stage_cfg(q.regs, s);
            src        = (s == 3 || s == 5) ? q.stage[(s == 3 || s == 5) ? s - 1 : s].out : q.in_clk;
            edge_seen  = (s == 3 || s == 5) ? (src != q.stage[s].prev_in) : 1'b1;
            per_halves = {ratio(c), 1'b0};
            // Correction stretches high to half the period, landing on an input fall for odd ratios
            hi_halves  = c.corr_dis ? {2'b00, c.high_cnt, 1'b0} + 7'h02
                                    : {1'b0, ratio(c)};
            d.stage[s].prev_in = src;
            if (q.sync) begin
                d.stage[s].halves   = '0;
                d.stage[s].wait_cnt = delay_halves(c);
                d.stage[s].out      = 1'b0;
                d.stage[s].prev_in  = 1'b0;
            end else if (c.bypass || c.direct) begin
                d.stage[s].out = src;
            end else if (edge_seen) begin
                if (q.stage[s].wait_cnt != '0) begin
                    d.stage[s].wait_cnt = q.stage[s].wait_cnt - 7'h01;
                end else begin
                    d.stage[s].out    = (q.stage[s].halves < hi_halves);
                    d.stage[s].halves = (q.stage[s].halves >= per_halves - 7'h01) ? '0
                                        : q.stage[s].halves + 7'h01;
                end
            end
        end

        d.out_b[0] = b_en[0] & d.stage[3].out;
        d.out_b[1] = b_en[1] & d.stage[5].out;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q      <= '0;
            q.wreq <= 1'b1;
            q.sync <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign clk_out         = {q.stage[5].out, q.stage[3].out, q.stage[1].out, q.stage[0].out};
    assign clk_out_b       = q.out_b;

    // ----------------------------------------------------------------
    // Checks on channel 0, the cascade, correction reset, the B output and the bus
    // ----------------------------------------------------------------
    cdp_pkg::cdp_stage_cfg_t c0;
    cdp_pkg::cdp_stage_cfg_t c1;
    cdp_pkg::cdp_stage_cfg_t c2;
    cdp_pkg::cdp_stage_cfg_t c5;
    logic [7:0] hi_q;
    logic [7:0] per_q;
    logic [7:0] since_q;
    logic [7:0] quiet_q;
    logic       first_q;
    logic       prev_q;

    assign c0 = stage_cfg(q.regs, 0);
    assign c1 = stage_cfg(q.regs, 1);
    assign c2 = stage_cfg(q.regs, 3);
    assign c5 = stage_cfg(q.regs, 5);

    // Helper counters read only by the checks below
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_q    <= '0;
            per_q   <= '0;
            since_q <= '0;
            quiet_q <= '0;
            first_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            prev_q <= q.stage[0].out;
            hi_q   <= q.stage[0].out ? hi_q + 8'h01 : 8'h00;
            if (q.sync) begin
                since_q <= '0;
                first_q <= 1'b1;
                per_q   <= '0;
            end else begin
                since_q <= (since_q == 8'hff) ? since_q : since_q + 8'h01;
                per_q   <= (q.stage[0].out && !prev_q) ? 8'h01
                           : (per_q == 8'hff) ? per_q : per_q + 8'h01;
                if (q.stage[0].out && !prev_q)
                    first_q <= 1'b0;
            end
            quiet_q <= (av_req.write || q.sync) ? 8'h00
                       : (quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic ch0_steady;
    // Steady: the sync was the last write, so counts and offset are those it loaded
    assign ch0_steady = !c0.bypass && !c0.direct && (quiet_q > since_q);

    sequence s_sync_pulse;
        q.sync;
    endsequence

    sequence s_restart;
        (q.stage[0].halves == '0) && (q.stage[2].halves == '0) && (q.stage[4].halves == '0);
    endsequence

    a_corr_reset_on: assert property ($fell(rst) |-> !c0.corr_dis && !c1.corr_dis
        && !c2.corr_dis && !c5.corr_dis)
        else $error("correction not enabled after reset");
    a_high_uncorr: assert property (ch0_steady && c0.corr_dis && $fell(q.stage[0].out) && !first_q
        |-> hi_q == 8'({3'b000, c0.high_cnt, 1'b0} + 8'h02))
        else $error("uncorrected high time wrong");
    a_high_corr: assert property (ch0_steady && !c0.corr_dis && $fell(q.stage[0].out) && !first_q
        |-> hi_q == {2'b00, ratio(c0)})
        else $error("corrected high time is not half the period");
    a_period_len: assert property (ch0_steady && $rose(q.stage[0].out) && !first_q
        |-> per_q == {1'b0, ratio(c0), 1'b0})
        else $error("divider period wrong");
    a_delay_short: assert property (ch0_steady && first_q && $rose(q.stage[0].out)
        && c0.code <= `CDP_CODE_SHORT_MAX |-> since_q == {2'b00, c0.code, 1'b0} + 8'h01)
        else $error("short start delay wrong");
    a_delay_long: assert property (ch0_steady && first_q && $rose(q.stage[0].out)
        && c0.code > `CDP_CODE_SHORT_MAX
        |-> since_q == 8'({2'b00, c0.code, 1'b0} - 8'h20 + {3'b000, c0.low_cnt, 1'b0} + 8'h03))
        else $error("long start delay wrong");
    a_sync_restart: assert property (s_sync_pulse |=> s_restart ##1 !q.stage[0].out || c0.bypass
        || c0.direct || c0.code == '0)
        else $error("counters did not restart at sync");
    a_cascade_follow: assert property (!c2.bypass && !$past(q.sync) && $changed(q.stage[3].out)
        |-> $past(q.stage[2].out) != $past(q.stage[2].out, 2))
        else $error("second stage moved without first stage edge");
    a_b_off: assert property (!b_en[0] |=> !clk_out_b[0])
        else $error("B output active while disabled");
    a_bus_answer: assert property ((av_req.read || av_req.write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

endmodule : cdp_channel_divider

//--- cdp_clock_receiver.sv
// Downstream receiver model: measures high time and period of one divided clock.
// Assumes the watched clock only changes on ref_clk edges, as the divider's outputs do.
`timescale 1ns/10ps

module cdp_clock_receiver (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_in,
    output logic [11:0]      high_len,
    output logic [11:0]      period_len,
    output logic [15:0]      rises
);
    logic        prev_q;
    logic [11:0] since_q;

    // ------------------------------------------------------------
    // Edge timing, in ref_clk cycles
    // ------------------------------------------------------------
    // The first period after reset is meaningless; callers wait for several rises
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q     <= 1'b0;
            since_q    <= 12'h000;
            high_len   <= 12'h000;
            period_len <= 12'h000;
            rises      <= 16'h0000;
        end else begin
            prev_q  <= clk_in;
            since_q <= since_q + 12'h001;
            if (clk_in && !prev_q) begin
                period_len <= since_q;
                since_q    <= 12'h001;
                rises      <= rises + 16'h0001;
            end
            if (!clk_in && prev_q) begin
                high_len <= since_q;
            end
        end
    end
endmodule : cdp_clock_receiver

//--- cdp_channel_divider_test.sv
// Self-checking bench for the channel dividers: registers, ratios, duty, delay and sync.
// Assumes cdp_map.svh on the include path and one bus wait state or more.
`timescale 1ns/10ps
`include "cdp_map.svh"

module cdp_channel_divider_test;
    typedef struct packed {
        logic [1:0]  ch;
        logic [7:0]  cnt1;
        logic [7:0]  cnt2;
        logic [7:0]  byp;
        logic        dis;
        logic [11:0] hi;
        logic [11:0] per;
    } cdp_row_t;

    logic                 ref_clk;
    logic                 rst;
    cdp_pkg::cdp_av_req_t av_req;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [3:0]           clk_out;
    logic [1:0]           clk_out_b;
    logic [5:0]           taps;
    logic [11:0]          hi_len [6];
    logic [11:0]          per_len [6];
    logic [15:0]          rises [6];
    logic [7:0]           rd;
    int                   n_errors;
    int                   samples_checked;
    int                   t0;
    int                   t1;
    int                   bad;
    // Ratios kept within 2..32; corrected rows use equal or low-one-more counts
    // For channels 0 and 1, byp bit 7 is the bypass and bit 1 the direct route
    cdp_row_t rows [11] = '{
        '{2'd0, 8'h00, 8'h00, 8'h80, 1'b1, 12'd1, 12'd2},
        '{2'd1, 8'h00, 8'h00, 8'h02, 1'b0, 12'd1, 12'd2},
        '{2'd0, 8'h11, 8'h00, 8'h00, 1'b0, 12'd4, 12'd8},
        '{2'd0, 8'h21, 8'h00, 8'h00, 1'b0, 12'd5, 12'd10},
        '{2'd1, 8'h21, 8'h00, 8'h00, 1'b1, 12'd4, 12'd10},
        '{2'd1, 8'h30, 8'h00, 8'h00, 1'b1, 12'd2, 12'd10},
        '{2'd1, 8'h00, 8'h00, 8'h00, 1'b1, 12'd2, 12'd4},
        '{2'd0, 8'hff, 8'h00, 8'h00, 1'b1, 12'd32, 12'd64},
        '{2'd3, 8'h11, 8'h11, 8'h30, 1'b0, 12'd1, 12'd2},
        '{2'd3, 8'h11, 8'h11, 8'h00, 1'b0, 12'd16, 12'd32},
        '{2'd2, 8'h21, 8'h00, 8'h20, 1'b1, 12'd4, 12'd10}
    };
    logic [7:0] codes [4] = '{8'h05, 8'h0f, 8'h10, 8'h12};
    int         lags [4]  = '{10, 30, 8, 12};

    assign taps = {clk_out_b, clk_out};

    cdp_channel_divider uut (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .av_req          (av_req),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .clk_out         (clk_out),
        .clk_out_b       (clk_out_b)
    );

    for (genvar i = 0; i < 6; i++) begin : g_rx
        cdp_clock_receiver rx (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .clk_in     (taps[i]),
            .high_len   (hi_len[i]),
            .period_len (per_len[i]),
            .rises      (rises[i])
        );
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Entered just after an edge; values read after the edge are the pre-edge ones
    task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        av_req.read       <= ~wr;
        av_req.write      <= wr;
        av_req.address    <= {idx, 2'b00};
        av_req.writedata  <= {24'h000000, wd};
        av_req.byteenable <= 4'hf;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) n_errors++;
        rd = avs_readdata[7:0];
        av_req.read  <= 1'b0;
        av_req.write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic wait_rises(input int ch, input int k);
        logic [15:0] r;
        int          n;
        r = rises[ch];
        n = 0;
        while (16'(rises[ch] - r) < k && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 5000) n_errors++;
    endtask : wait_rises

    task automatic run_row(input cdp_row_t r);
        logic [8:0] b;
        if (r.ch < 2'd2) begin
            b = r.ch[0] ? `CDP_IDX_CH1_COUNT : `CDP_IDX_CH0_COUNT;
            bus(1'b1, b, r.cnt1);
            bus(1'b1, b + 9'h001, {r.byp[7], 7'h00});
            bus(1'b1, b + 9'h002, {6'h00, r.byp[1], r.dis});
        end else begin
            b = r.ch[0] ? `CDP_IDX_CH3_S1 : `CDP_IDX_CH2_S1;
            bus(1'b1, b, r.cnt1);
            bus(1'b1, b + 9'h002, r.cnt2);
            bus(1'b1, b + 9'h003, r.byp);
            bus(1'b1, b + 9'h004, {7'h00, r.dis});
        end
        bus(1'b1, `CDP_IDX_SYNC, 8'h01);
        wait_rises(r.ch, 3);
        check("high time", {4'h0, hi_len[r.ch]}, {4'h0, r.hi});
        check("period", {4'h0, per_len[r.ch]}, {4'h0, r.per});
    endtask : run_row

    // Sync, then note the first cycle each single-stage output is seen high
    task automatic first_rise();
        int n;
        t0 = -1;
        t1 = -1;
        bus(1'b1, `CDP_IDX_SYNC, 8'h01);
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            if (t0 < 0 && clk_out[0] === 1'b1) t0 = n;
            if (t1 < 0 && clk_out[1] === 1'b1) t1 = n;
        end
    endtask : first_rise

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        av_req = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check("b outputs after reset", {14'h0, clk_out_b}, 16'h0000);
        bus(1'b0, `CDP_IDX_CH0_CORR, 8'h00);
        check("ch0 correction reset", {8'h00, rd}, 16'h0000);
        bus(1'b0, `CDP_IDX_CH2_CORR, 8'h00);
        check("ch2 correction reset", {8'h00, rd}, 16'h0000);
        bus(1'b0, `CDP_IDX_B_ENABLE, 8'h00);
        check("b enable reset", {8'h00, rd}, 16'h0000);
        bus(1'b1, `CDP_IDX_CH0_OFFSET, 8'hff);
        bus(1'b0, `CDP_IDX_CH0_OFFSET, 8'h00);
        check("offset mask", {8'h00, rd}, 16'h009f);
        bus(1'b1, `CDP_IDX_CH0_OFFSET, 8'h00);
        bus(1'b1, 9'h010, 8'h5a);
        bus(1'b0, 9'h010, 8'h00);
        check("unmapped read", {8'h00, rd}, 16'h0000);
        foreach (rows[i]) run_row(rows[i]);
        // B copy of channel 2 only
        bus(1'b1, `CDP_IDX_B_ENABLE, 8'h01);
        wait_rises(4, 3);
        check("b period", {4'h0, per_len[4]}, 16'd10);
        check("ch3 b still off", {15'h0, clk_out_b[1]}, 16'h0000);
        // Equal ratio-8 dividers on both single-stage channels, zero offsets
        bus(1'b1, `CDP_IDX_CH0_COUNT, 8'h33);
        bus(1'b1, `CDP_IDX_CH1_COUNT, 8'h33);
        bus(1'b1, `CDP_IDX_CH1_CORR, 8'h00);
        bus(1'b1, `CDP_IDX_CH0_CORR, 8'h00);
        first_rise();
        check("zero offset lag", 16'(t0 - t1), 16'h0000);
        bus(1'b1, `CDP_IDX_CH0_OFFSET, 8'h05);
        bad = 0;
        repeat (40) begin
            @(posedge ref_clk);
            if (clk_out[0] !== clk_out[1]) bad++;
        end
        check("offset before sync", 16'(bad), 16'h0000);
        foreach (codes[i]) begin
            bus(1'b1, `CDP_IDX_CH0_OFFSET, codes[i]);
            first_rise();
            check("offset lag", 16'(t0 - t1), 16'(lags[i]));
        end
        // Second reset in mid-run: outputs and registers back to idle
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check("outputs after mid reset", {10'h000, clk_out_b, clk_out}, 16'h0000);
        bus(1'b0, `CDP_IDX_CH2_CORR, 8'h00);
        check("ch2 correction after mid reset", {8'h00, rd}, 16'h0000);
        end_sim();
    end
endmodule : cdp_channel_divider_test
